// *** hw/sacc_control.sv ***
// Purpose: Conversion sequencer, result latches and bus output control.
// Assumes: Comparator decision arrives synchronously, one per bit cycle.
// Notes: Bit cycle time is stretched so twelve bits fit the conversion limit.
`timescale 1ns/100ps
`default_nettype none
`include "sacc_map.svh"
module sacc_control
  import sacc_pkg::*;
#(
  parameter int Width = 12,
  parameter int BitCycles = 4
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic chipSelectN,
  input wire logic convert_start_n,
  input wire logic readStrobeN,
  input wire logic power_down_n,
  input wire logic power_down_variety_select,
  input wire logic compareHigh,
  output logic busyN,
  output logic sampleHold,
  output logic [Width-1:0] trialWord,
  output sacc_result_t result_bits,
  output sacc_power_t powerMode
);
  sacc_state_t state_q, state_d;
  logic startLevel_q;
  logic [Width-1:0] approximation_register_q;
  logic [Width-1:0] latch_q;
  logic [$clog2(Width)-1:0] bitIdx_q;
  logic [$clog2(BitCycles+1)-1:0] phase_q;
  logic [Width-1:0] bitMask;
  logic startQual;
  logic startEdge;
  logic bitDone;
  logic readEnable;
  logic [Width-1:0] decided;
  // The comparator works on the level counted from negative full scale, so flipping
  // the top bit on the way into the latches gives the two's complement code.
  localparam logic [Width-1:0] SignBit = {1'b1, {(Width-1){1'b0}}};

  // Chip select gates both the start and the read strobe.
  // A start held low with chip select low never fires twice, since an edge needs the gated level to drop first.
  assign startQual = ~convert_start_n & ~chipSelectN;
  assign startEdge = startQual & ~startLevel_q;
  assign readEnable = ~readStrobeN & ~chipSelectN;
  assign bitMask = {{(Width-1){1'b0}}, 1'b1} << (Width - 1 - bitIdx_q);
  assign bitDone = (phase_q == ($clog2(BitCycles+1))'(BitCycles - 1));
  // The trial word stays offset binary because the DAC counts from negative full scale.
  // Only the latched result carries the sign flip.
  assign trialWord = approximation_register_q | bitMask;
  assign decided = compareHigh ? trialWord : approximation_register_q;
  assign busyN = (state_q == SACC_ACQ);
  assign sampleHold = (state_q != SACC_ACQ);
  assign result_bits.value = latch_q;
  assign result_bits.driveEn = readEnable ? {Width{1'b1}} : {Width{1'b0}};
  // Nap keeps logic awake; a conversion already running is allowed to finish.
  assign powerMode = power_down_n ? SACC_ACTIVE :
    (power_down_variety_select ? SACC_NAP : SACC_SLEEP);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SACC_ACQ:
      begin
        if (startEdge && power_down_n)
        begin
          state_d = SACC_CONV;
        end
      end
      SACC_CONV:
      begin
        if (bitDone && bitIdx_q == ($clog2(Width))'(Width - 1))
        begin
          state_d = SACC_LOAD;
        end
      end
      SACC_LOAD: state_d = SACC_ACQ;
      default: state_d = SACC_ACQ;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= SACC_ACQ;
      startLevel_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      startLevel_q <= startQual;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      approximation_register_q <= {Width{1'b0}};
      bitIdx_q <= '0;
      phase_q <= '0;
    end
    else if (state_q == SACC_ACQ)
    begin
      approximation_register_q <= {Width{1'b0}};
      bitIdx_q <= '0;
      phase_q <= '0;
    end
    else if (state_q == SACC_CONV)
    begin
      phase_q <= bitDone ? '0 : phase_q + 1'b1;
      if (bitDone)
      begin
        approximation_register_q <= decided;
        bitIdx_q <= bitIdx_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      latch_q <= `SACC_RESULT_RST;
    end
    else if (state_q == SACC_LOAD)
    begin
      latch_q <= approximation_register_q ^ SignBit;
    end
  end

  // A 32-bit int counter only wraps long after ConvMax, so a stuck conversion still trips the limit check.
  localparam int ConvMax = `SACC_TCONV_CYC;
  localparam int ConvCycles = Width * BitCycles + 1;
  int convCount;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      convCount <= 0;
    end
    else
    begin
      convCount <= busyN ? 0 : convCount + 1;
    end
  end

  sequence seqStart;
    startEdge && power_down_n && busyN;
  endsequence

  AST_START_BUSY: assert property (@(posedge clk) disable iff (!resetn)
    seqStart |=> !busyN)
    else $error("Busy did not fall after a start edge.");
  AST_CS_GATES: assert property (@(posedge clk) disable iff (!resetn)
    (busyN && chipSelectN) |=> busyN)
    else $error("Conversion started without chip select.");
  AST_DRIVE: assert property (@(posedge clk) disable iff (!resetn)
    (result_bits.driveEn != '0) == (!readStrobeN && !chipSelectN))
    else $error("Output drive does not follow read and chip select.");
  AST_BUSY_LEN: assert property (@(posedge clk) disable iff (!resetn)
    seqStart |=> (!busyN)[*8])
    else $error("Busy rose too early.");
  AST_DATA_AT_BUSY: assert property (@(posedge clk) disable iff (!resetn)
    $rose(busyN) |-> latch_q == ($past(approximation_register_q) ^ SignBit))
    else $error("Result not loaded when busy rose.");
  AST_POWER: assert property (@(posedge clk) disable iff (!resetn)
    !power_down_n |-> powerMode != SACC_ACTIVE)
    else $error("Power-down not entered.");
  AST_VARIETY: assert property (@(posedge clk) disable iff (!resetn)
    !power_down_n |-> (powerMode == (power_down_variety_select ? SACC_NAP : SACC_SLEEP)))
    else $error("Wrong power-down variety.");
  AST_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
    seqStart |=> approximation_register_q == '0)
    else $error("Approximation register not cleared at start.");
  AST_NO_RESTART: assert property (@(posedge clk) disable iff (!resetn)
    (!busyN && startEdge) |=> bitIdx_q >= $past(bitIdx_q))
    else $error("Conversion restarted while busy.");
  AST_MSB_FIRST: assert property (@(posedge clk) disable iff (!resetn)
    seqStart |=> bitMask[Width-1])
    else $error("First decision is not the most significant bit.");
  AST_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    !busyN && !$rose(busyN) |=> $stable(latch_q) || $rose(busyN))
    else $error("Result latch changed during conversion.");
  AST_CONV_TIME: assert property (@(posedge clk) disable iff (!resetn)
    convCount <= ConvMax && ConvCycles + 1 <= ConvMax)
    else $error("Conversion exceeded its time limit.");

  // The checks below watch the sequencer's internal state, so a broken bit schedule
  // shows up as a wrong count or order rather than only as a wrong result.
  sequence seqLastBit;
    state_q == SACC_CONV && bitDone && bitIdx_q == ($clog2(Width))'(Width - 1);
  endsequence

  sequence seqLoadThenIdle;
    state_q == SACC_LOAD ##1 busyN;
  endsequence

  AST_BUSY_EXACT: assert property (@(posedge clk) disable iff (!resetn)
    $rose(busyN) |-> convCount == ConvCycles)
    else $error("Busy low time differs from the bit schedule.");
  AST_LOAD_AFTER_LSB: assert property (@(posedge clk) disable iff (!resetn)
    seqLastBit |=> seqLoadThenIdle)
    else $error("Result load did not follow the last bit decision.");
  AST_SIGN_CODE: assert property (@(posedge clk) disable iff (!resetn)
    $rose(busyN) |-> latch_q[Width-1] != $past(approximation_register_q[Width-1]))
    else $error("Result sign bit is not in two's complement sense.");
  AST_LSB_LAST: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == SACC_LOAD) |-> bitIdx_q == ($clog2(Width))'(Width))
    else $error("Load reached before the least significant bit was decided.");
  AST_BITS_BELOW: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == SACC_CONV) |-> (approximation_register_q & (bitMask - 1'b1)) == '0)
    else $error("A lower bit was decided before the bit under trial.");
  AST_NO_RESTART_PHASE: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == SACC_CONV && startEdge && !bitDone) |=> phase_q == $past(phase_q) + 1'b1)
    else $error("A start edge disturbed the running bit slot.");
  AST_PD_NO_START: assert property (@(posedge clk) disable iff (!resetn)
    (!power_down_n && busyN) |=> busyN)
    else $error("Conversion started in power-down.");
endmodule : sacc_control
`default_nettype wire

// *** hw/sacc_map.svh ***
// Purpose: Constants for the sampling converter control block.
// Assumes: 100 MHz clock, all pins synchronous to it.
// Notes: Behaviour list of the block follows.
// Behaviour
// - A falling edge of convert_start_n begins a conversion unless power_down_n is low.
// - Start and read inputs are ignored unless chip select is low.
// - Result pins driven only while read strobe and chip select are low.
// - Busy is low throughout a conversion and rises at its end.
// - New result is valid on the outputs when busy rises.
// - Power-down is entered whenever power_down_n is low.
// - Variety select low gives sleep, high gives nap.
// - The approximation register is cleared when a conversion starts.
// - Start edges during a conversion have no effect.
// - Bits are decided one at a time, most significant first.
// - The finished approximation word is loaded into the result latches.
// - The result is a two's complement word.
// - Each conversion completes within 0.75 us of its start edge.
`ifndef SACC_MAP_SVH
`define SACC_MAP_SVH
`define SACC_CLK_NS 10
`define SACC_TCONV_MAX_NS 750
`define SACC_TCONV_CYC (`SACC_TCONV_MAX_NS / `SACC_CLK_NS)
`define SACC_TACQ_MIN_NS 100
`define SACC_TACQ_CYC ((`SACC_TACQ_MIN_NS + `SACC_CLK_NS - 1) / `SACC_CLK_NS)
`define SACC_TWAKE_NS 200
`define SACC_TWAKE_CYC ((`SACC_TWAKE_NS + `SACC_CLK_NS - 1) / `SACC_CLK_NS)
`define SACC_RESULT_RST 12'h000
`endif

// *** hw/sacc_pkg.sv ***
package sacc_pkg;
  typedef enum logic [1:0] {
    SACC_ACQ = 2'b00,
    SACC_CONV = 2'b01,
    SACC_LOAD = 2'b10
  } sacc_state_t;
  typedef enum logic [1:0] {
    SACC_ACTIVE = 2'b00,
    SACC_NAP = 2'b01,
    SACC_SLEEP = 2'b10
  } sacc_power_t;
  typedef struct packed {
    logic [11:0] value;
    logic [11:0] driveEn;
  } sacc_result_t;
endpackage : sacc_pkg

// *** tb/sacc_adc_model.sv ***
// Purpose: Comparator model that holds the sampled input code.
// Assumes: Held level counts from negative full scale and is compared unsigned.
// Notes: Tracks the input while the hold is low.
`timescale 1ns/100ps
`default_nettype none
module sacc_adc_model
(
  input wire logic clk,
  input wire logic sampleHold,
  input wire logic [11:0] analogCode,
  input wire logic [11:0] trialWord,
  output logic compareHigh
);
  logic [11:0] held_q;
  always_ff @(posedge clk)
  begin
    if (!sampleHold)
      held_q <= analogCode;
  end
  // A late hold would pick up the changed input and spoil the result.
  assign compareHigh = (trialWord <= held_q);
endmodule : sacc_adc_model
`default_nettype wire

// *** tb/sacc_control_tb_top.sv ***
// Purpose: Self-checking bench for the conversion control block.
// Assumes: Default bit slot length of four cycles.
// Notes: Host pins are driven on the rising edge.
`timescale 1ns/100ps
`default_nettype none
module sacc_control_tb_top;
  import sacc_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic csN = 1'b1;
  logic startN = 1'b1;
  logic rdN = 1'b1;
  logic pdN = 1'b1;
  logic varSel = 1'b0;
  logic [11:0] analogCode = 12'h000;
  logic compareHigh, busyN, sampleHold;
  logic [11:0] trialWord;
  sacc_result_t result;
  sacc_power_t powerMode;
  int num_errors = 0;
  int samples_checked = 0;
  logic [11:0] codes [5] = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'ha5a};
  always #5 clk = ~clk;
  sacc_control dut (.clk(clk), .resetn(resetn), .chipSelectN(csN),
    .convert_start_n(startN), .readStrobeN(rdN), .power_down_n(pdN),
    .power_down_variety_select(varSel), .compareHigh(compareHigh), .busyN(busyN),
    .sampleHold(sampleHold), .trialWord(trialWord), .result_bits(result),
    .powerMode(powerMode));
  sacc_adc_model model (.clk(clk), .sampleHold(sampleHold), .analogCode(analogCode),
    .trialWord(trialWord), .compareHigh(compareHigh));
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  // Input levels count from negative full scale; flipping the sign bit gives the code.
  localparam logic [11:0] SignBit = 12'h800;
  task automatic conv(input logic [11:0] code, input logic [11:0] old);
    int n;
    n = 0;
    @(posedge clk);
    csN <= 1'b0;
    startN <= 1'b0;
    analogCode <= code;
    repeat (2) @(posedge clk);
    #1;
    chk(busyN, 1'b0);
    chk(sampleHold, 1'b1);
    chk(trialWord, 12'h800);
    while (busyN !== 1'b1 && n < 100)
    begin
      chk(result.value, old);
      @(posedge clk);
      startN <= (n == 5);
      analogCode <= ~code;
      #1;
      n++;
    end
    chk(n[11:0], 12'd48);
    chk(result.value, code ^ SignBit);
    chk(sampleHold, 1'b0);
    @(posedge clk);
    startN <= 1'b1;
    // The acquisition gap is kept by the host side.
    repeat (10) @(posedge clk);
  endtask : conv
  task automatic rd(input logic cs, input logic [11:0] en, input logic [11:0] val);
    @(posedge clk);
    csN <= cs;
    rdN <= 1'b0;
    @(posedge clk);
    #1;
    chk(result.driveEn, en);
    chk(result.value, val);
    @(posedge clk);
    rdN <= 1'b1;
    @(posedge clk);
    #1;
    chk(result.driveEn, 12'h000);
  endtask : rd
  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk(busyN, 1'b1);
    chk(result.value, 12'h000);
    for (int i = 0; i < 5; i++)
    begin
      conv(codes[i], (i == 0) ? 12'h000 : codes[i-1] ^ SignBit);
      rd(1'b0, 12'hfff, codes[i] ^ SignBit);
    end
    rd(1'b1, 12'h000, codes[4] ^ SignBit);
    $display("conversion and read tests done");
    @(posedge clk);
    csN <= 1'b1;
    startN <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk(busyN, 1'b1);
    @(posedge clk);
    startN <= 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      @(posedge clk);
      varSel <= m[0];
      @(posedge clk);
      pdN <= 1'b0;
      csN <= 1'b0;
      @(posedge clk);
      startN <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk(powerMode, (m == 1) ? SACC_NAP : SACC_SLEEP);
      chk(busyN, 1'b1);
      @(posedge clk);
      startN <= 1'b1;
      pdN <= 1'b1;
      repeat (20) @(posedge clk);
    end
    #1;
    chk(powerMode, SACC_ACTIVE);
    $display("power-down test done");
    stop_test();
  end
  initial
  begin
    #50000;
    num_errors++;
    stop_test();
  end
endmodule : sacc_control_tb_top
`default_nettype wire
